// ==== design/dvic_top.sv ====
/*
 * Dual vectored interrupt controller: source gathering, per-half
 * remapping, forcing, enables, fast steering and priority resolution.
 * Assumes all request inputs and configuration are synchronous to
 * mclk_in and that configuration is held steady while in use.
 */
module dvic_top
   import dvic_pkg::*;
(
   // Clock and reset
   input  wire logic                  mclk_in,
   input  wire logic                  rst_in,
   // Peripheral requests
   input  wire logic                  watchdog_in,
   input  wire logic                  firmware_irq_in,
   input  wire logic                  debug_rx_in,
   input  wire logic                  debug_tx_in,
   input  wire logic [19:0]           timer_flags_in,
   input  wire logic                  usb_hi_in,
   input  wire logic                  usb_lo_in,
   input  wire logic [7:0]            clock_ctl_in,
   input  wire logic [7:0]            mac_in,
   input  wire logic [7:0]            dma_in,
   input  wire logic [7:0]            can_in,
   input  wire logic [7:0]            motor_in,
   input  wire logic                  adc_done_in,
   input  wire logic [14:0]           uart_in,
   input  wire logic [5:0]            i2c_in,
   input  wire logic [15:0]           ssp_in,
   input  wire logic                  low_voltage_in,
   input  wire logic [2:0]            calendar_in,
   input  wire logic [31:0]           wake_in,
   input  wire logic                  usb_resume_in,
   input  wire logic [3:0]            prefetch_branch_cache_in,
   // Firmware configuration
   input  wire logic [31:0]           chan_en_in,
   input  wire logic [31:0]           force_in,
   input  wire logic [63:0]           prim_map_in,
   input  wire logic [63:0]           sec_map_in,
   input  wire logic                  fast_en_in,
   input  wire dvic_pkg::dvic_chan_type fast_chan_in,
   // Core side
   output logic                       fast_request_out,
   output logic                       vector_request_out,
   output dvic_pkg::dvic_chan_type    active_chan_out,
   output dvic_pkg::dvic_chan_type    active_source_out,
   output logic [31:0]                vector_addr_out
);
   import dvic_pkg::*;

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [31:0]   src;
      logic          fast;
      logic          vreq;
      dvic_chan_type chan;
      dvic_chan_type srcid;
      logic [31:0]   vec;
   } dvic_state_type;

   dvic_state_type s_q;
   dvic_state_type s_d;
   logic [31:0]    raw;
   logic [31:0]    pend;
   logic [31:0]    fmask;
   logic [31:0]    vect;
   dvic_chan_type  map_src [NCH];

   // ************************************************************
   // Source gathering
   // ************************************************************
   always_comb begin
      raw = 32'h0000_0000;
      raw[SRC_WATCHDOG] = watchdog_in;
      raw[SRC_FW]       = firmware_irq_in;
      raw[SRC_DBG_RX]   = debug_rx_in;
      raw[SRC_DBG_TX]   = debug_tx_in;
      for (int t = 0; t < 4; t++) begin
         raw[SRC_TIMER0 + t] = |timer_flags_in[t*5 +: 5];
      end
      raw[SRC_USB_HI]   = usb_hi_in;
      raw[SRC_USB_LO]   = usb_lo_in;
      raw[SRC_CLK_CTL]  = |clock_ctl_in;
      raw[SRC_MAC]      = |mac_in;
      raw[SRC_DMA]      = |dma_in;
      raw[SRC_CAN]      = |can_in;
      raw[SRC_MOTOR]    = |motor_in;
      raw[SRC_ADC]      = adc_done_in;
      for (int u = 0; u < 3; u++) begin
         raw[SRC_UART0 + u] = |uart_in[u*5 +: 5];
      end
      for (int i = 0; i < 2; i++) begin
         raw[SRC_I2C0 + i] = |i2c_in[i*3 +: 3];
         raw[SRC_SSP0 + i] = |ssp_in[i*8 +: 8];
      end
      raw[SRC_LOW_VOLT] = low_voltage_in;
      raw[SRC_CALENDAR] = |calendar_in;
      raw[SRC_WAKE_ALL] = |wake_in;
      for (int g = 0; g < 4; g++) begin
         raw[SRC_WAKE_GRP + g] = |wake_in[g*WAKE_GRP_W +: WAKE_GRP_W];
      end
      raw[SRC_USB_RES]  = usb_resume_in;
      raw[SRC_PREFETCH_BRANCH_CACHE]   = |prefetch_branch_cache_in;
   end

   // ************************************************************
   // Channel requests
   // ************************************************************
   // Remap stays inside a half, so the half bit of a source never
   // changes and primary sources keep their lead.
   always_comb begin
      pend  = 32'h0000_0000;
      fmask = 32'h0000_0000;
      for (int k = 0; k < NCH; k++) begin
         if (k < HALF) begin
            map_src[k] = {1'b0, prim_map_in[k*4 +: 4]};
         end else begin
            map_src[k] = {1'b1, sec_map_in[(k-HALF)*4 +: 4]};
         end
         // Levels only: a channel is pending while its source holds it
         pend[k] = (s_q.src[map_src[k]] | force_in[k]) & chan_en_in[k];
      end
      if (fast_en_in) begin
         fmask[fast_chan_in] = 1'b1;
      end
      vect = pend & ~fmask;
   end

   // ************************************************************
   // Resolution
   // ************************************************************
   always_comb begin
      s_d       = s_q;
      s_d.src   = raw;
      s_d.fast  = |(pend & fmask);
      s_d.vreq  = |vect;
      s_d.chan  = ID_RESET;
      s_d.srcid = ID_RESET;
      s_d.vec   = VEC_IDLE;
      // Walk from lowest priority up so channel 0 is written last
      for (int k = NCH - 1; k >= 0; k--) begin
         if (vect[k]) begin
            s_d.chan  = 5'(k);
            s_d.srcid = map_src[k];
            s_d.vec   = VEC_BASE + VEC_STRIDE * 32'(k);
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         s_q <= '{src: 32'h0000_0000, fast: 1'b0, vreq: 1'b0,
                  chan: ID_RESET, srcid: ID_RESET, vec: VEC_IDLE};
      end else begin
         s_q <= s_d;
      end
   end

   assign fast_request_out   = s_q.fast;
   assign vector_request_out = s_q.vreq;
   assign active_chan_out    = s_q.chan;
   assign active_source_out  = s_q.srcid;
   assign vector_addr_out    = s_q.vec;

   // ************************************************************
   // Checks
   // ************************************************************
   // One cycle from sampled sources to the request outputs
   chk_fast_route: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      (|(pend & fmask)) |=> fast_request_out)
      else $error("fast request missing");

   chk_vec_or: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      1'b1 |=> vector_request_out == (|$past(vect)))
      else $error("vectored request not the OR");

   chk_prio_win: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      vector_request_out |-> ((($past(vect) >> active_chan_out) & 32'h1) == 32'h1) &&
      (($past(vect) & ((32'h1 << active_chan_out) - 32'h1)) == 32'h0))
      else $error("winner not highest priority");

   chk_vec_addr: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      vector_request_out |->
      vector_addr_out == VEC_BASE + VEC_STRIDE * {27'h0, active_chan_out})
      else $error("vector address wrong");

   chk_half_kept: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      vector_request_out |-> active_source_out[4] == active_chan_out[4])
      else $error("source left its half");

   chk_en_off: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      chan_en_in == 32'h0 |=> !fast_request_out && !vector_request_out)
      else $error("disabled channel raised a request");

   chk_force_top: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      (force_in[0] && chan_en_in[0] && !fast_en_in) |=>
      vector_request_out && active_chan_out == 5'h00)
      else $error("forced channel 0 not served");

   chk_wake_all: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      (|wake_in) |=> s_q.src[SRC_WAKE_ALL])
      else $error("wake OR not sampled");

   chk_wake_grp: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      (|wake_in[15:8]) |=> s_q.src[SRC_WAKE_GRP + 1] ##1 $past(s_q.src[27]))
      else $error("wake group 1 not sampled");

   chk_fast_cause: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      fast_request_out |-> ($past(pend) & $past(fmask)) != 32'h0)
      else $error("fast request without a steered channel");

   chk_fast_off: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      !fast_en_in |=> !fast_request_out)
      else $error("fast request while steering is off");

   chk_fast_excl: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      vector_request_out |-> (($past(fmask) >> active_chan_out) & 32'h1) == 32'h0)
      else $error("fast channel won the vectored path");

   chk_en_win: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      vector_request_out |-> (($past(chan_en_in) >> active_chan_out) & 32'h1) == 32'h1)
      else $error("disabled channel won resolution");

   chk_idle_out: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      !vector_request_out |->
      active_chan_out == ID_RESET && active_source_out == ID_RESET && vector_addr_out == VEC_IDLE)
      else $error("idle outputs not cleared");

   chk_prim_lead: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      (vector_request_out && active_chan_out[4]) |-> ($past(vect) & 32'h0000_ffff) == 32'h0)
      else $error("secondary won over a primary request");

   chk_map_prim: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      (vector_request_out && !active_chan_out[4]) |->
      active_source_out == {1'b0, 4'($past(prim_map_in) >> (4 * active_chan_out))})
      else $error("primary remap not followed");

   chk_map_sec: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      (vector_request_out && active_chan_out[4]) |->
      active_source_out == {1'b1, 4'($past(sec_map_in) >> (4 * active_chan_out[3:0]))})
      else $error("secondary remap not followed");

   chk_force_any: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      ((force_in & chan_en_in & ~fmask) != 32'h0) |=> vector_request_out)
      else $error("forced channel not requested");

   chk_src_level: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      1'b1 |=> s_q.src == $past(raw))
      else $error("source levels not sampled");

   chk_fw_src: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      firmware_irq_in |=> s_q.src[SRC_FW])
      else $error("firmware source not sampled");

   chk_watchdog_src: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      watchdog_in |=> s_q.src[SRC_WATCHDOG])
      else $error("watchdog source not sampled");

   chk_timer_or: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      (|timer_flags_in[4:0]) |=> s_q.src[SRC_TIMER0])
      else $error("timer flags OR not sampled");

   chk_uart_or: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      (|uart_in[4:0]) |=> s_q.src[SRC_UART0])
      else $error("uart OR not sampled");

   chk_calendar_or: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      (|calendar_in) |=> s_q.src[SRC_CALENDAR])
      else $error("calendar OR not sampled");

   chk_wake_last: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      (|wake_in[31:24]) |=> s_q.src[SRC_WAKE_GRP + 3])
      else $error("wake group 3 not sampled");

   chk_usb_res: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      usb_resume_in |=> s_q.src[SRC_USB_RES])
      else $error("resume source not sampled");

endmodule

// ==== design/dvic_pkg.sv ====
/*
 * Constants of the dual vectored interrupt controller: source slots,
 * half sizes, vector layout and reset values.
 * Assumes one bus clock and a synchronous active-high reset.
 */
// Contract
// - Thirty-two prioritised channels drive a fast and a vectored request; fast outranks.
// - Any one of the 32 channels can be steered to the fast request.
// - The fast request carries no vector and needs no priority resolution.
// - The vectored request is the OR of all channels routed to it.
// - Priority follows channel number: channel 0 highest, channel 31 lowest.
// - Within each half, firmware remaps which source feeds which channel.
// - Every primary-half request beats every secondary-half request.
// - Winner is resolved; service routine reads source identity and vector address.
// - Firmware may force any channel; slot 1 is the firmware interrupt.
// - Slot 25 is the OR of all 32 wake-up inputs.
// - Slots 26 to 29 each OR one group of 8 wake-up inputs.
// - Slot 0 watchdog; slots 2 and 3 debug receive and transmit.
// - Slots 4 to 7 OR five flags of one general timer each.
// - Slots 8, 9 USB high and low; slot 10 clock control unit.
// - Slots 11 to 15: MAC, DMA OR, CAN, motor OR, conversion end.
// - Slots 16 to 18 UARTs; 19 and 20 the two I2C channels.
// - Slots 21, 22 serial ports; 23 low voltage; 24 calendar alarms.
// - Slot 30 USB resume wake-up; slot 31 prefetch and branch cache.
package dvic_pkg;
   localparam int NCH    = 32;
   localparam int HALF   = 16;
   localparam int SRC_WATCHDOG = 0;
   localparam int SRC_FW       = 1;
   localparam int SRC_DBG_RX   = 2;
   localparam int SRC_DBG_TX   = 3;
   localparam int SRC_TIMER0   = 4;
   localparam int SRC_USB_HI   = 8;
   localparam int SRC_USB_LO   = 9;
   localparam int SRC_CLK_CTL  = 10;
   localparam int SRC_MAC      = 11;
   localparam int SRC_DMA      = 12;
   localparam int SRC_CAN      = 13;
   localparam int SRC_MOTOR    = 14;
   localparam int SRC_ADC      = 15;
   localparam int SRC_UART0    = 16;
   localparam int SRC_I2C0     = 19;
   localparam int SRC_SSP0     = 21;
   localparam int SRC_LOW_VOLT = 23;
   localparam int SRC_CALENDAR = 24;
   localparam int SRC_WAKE_ALL = 25;
   localparam int SRC_WAKE_GRP = 26;
   localparam int SRC_USB_RES  = 30;
   localparam int SRC_PREFETCH_BRANCH_CACHE   = 31;
   localparam int WAKE_GRP_W   = 8;
   localparam logic [31:0] VEC_BASE   = 32'h0000_0100;
   localparam logic [31:0] VEC_STRIDE = 32'h0000_0004;
   localparam logic [31:0] VEC_IDLE   = 32'h0000_0000;
   localparam logic [4:0]  ID_RESET   = 5'h00;
   typedef logic [4:0] dvic_chan_type;
endpackage

// ==== sim/dvic_core_model.sv ====
/*
 * Core-side partner: takes the fast and vectored requests and plays
 * the service routine read of identity and vector address.
 * Assumes dvic_top outputs are synchronous to mclk_in.
 */
module dvic_core_model
   import dvic_pkg::*;
(
   // Clock and reset
   input  wire logic                    mclk_in,
   input  wire logic                    rst_in,
   // Controller outputs
   input  wire logic                    fast_req_in,
   input  wire logic                    vec_req_in,
   input  wire dvic_pkg::dvic_chan_type source_in,
   input  wire logic [31:0]             vector_in,
   // Values seen by the service routine
   output logic                         in_fast_out,
   output dvic_pkg::dvic_chan_type      read_source_out,
   output logic [31:0]                  read_vector_out
);
   timeunit 1ns;
   timeprecision 1ns;
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         in_fast_out     <= 1'b0;
         read_source_out <= '0;
         read_vector_out <= '0;
      end else begin
         in_fast_out <= fast_req_in; // Entered directly, no read
         // Fast handler runs first, vectored read waits
         if (vec_req_in && !fast_req_in) begin
            read_source_out <= source_in;
            read_vector_out <= vector_in;
         end
      end
   end
endmodule

// ==== sim/dvic_top_tb.sv ====
/*
 * Self-checking bench for dvic_top with a core-side partner model.
 * Assumes the two-edge source latency and one-edge config latency.
 */
module dvic_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import dvic_pkg::*;
   logic mclk_in, rst_in, watchdog_in, firmware_irq_in, debug_rx_in, debug_tx_in;
   logic usb_hi_in, usb_lo_in, adc_done_in, low_voltage_in, usb_resume_in, fast_en_in;
   logic fast_request_out, vector_request_out, in_fast;
   logic [19:0] timer_flags_in;
   logic [7:0]  clock_ctl_in, mac_in, dma_in, can_in, motor_in;
   logic [14:0] uart_in;
   logic [5:0]  i2c_in;
   logic [15:0] ssp_in;
   logic [2:0]  calendar_in;
   logic [3:0]  prefetch_branch_cache_in;
   logic [31:0] wake_in, chan_en_in, force_in, vector_addr_out, read_vector;
   logic [63:0] prim_map_in, sec_map_in;
   dvic_chan_type fast_chan_in, active_chan_out, active_source_out, read_source;
   int fail_count;
   int samples_checked;
   localparam logic [63:0] IDENT = 64'hfedc_ba98_7654_3210;
   dvic_top DUT (
      .mclk_in(mclk_in), .rst_in(rst_in), .watchdog_in(watchdog_in), .firmware_irq_in(firmware_irq_in),
      .debug_rx_in(debug_rx_in), .debug_tx_in(debug_tx_in), .timer_flags_in(timer_flags_in),
      .usb_hi_in(usb_hi_in), .usb_lo_in(usb_lo_in), .clock_ctl_in(clock_ctl_in), .mac_in(mac_in),
      .dma_in(dma_in), .can_in(can_in), .motor_in(motor_in), .adc_done_in(adc_done_in), .uart_in(uart_in),
      .i2c_in(i2c_in), .ssp_in(ssp_in), .low_voltage_in(low_voltage_in), .calendar_in(calendar_in),
      .wake_in(wake_in), .usb_resume_in(usb_resume_in), .prefetch_branch_cache_in(prefetch_branch_cache_in), .chan_en_in(chan_en_in),
      .force_in(force_in), .prim_map_in(prim_map_in), .sec_map_in(sec_map_in), .fast_en_in(fast_en_in),
      .fast_chan_in(fast_chan_in), .fast_request_out(fast_request_out),
      .vector_request_out(vector_request_out), .active_chan_out(active_chan_out),
      .active_source_out(active_source_out), .vector_addr_out(vector_addr_out));
   dvic_core_model core (.mclk_in(mclk_in), .rst_in(rst_in), .fast_req_in(fast_request_out),
      .vec_req_in(vector_request_out), .source_in(active_source_out), .vector_in(vector_addr_out),
      .in_fast_out(in_fast), .read_source_out(read_source), .read_vector_out(read_vector));
   initial begin
      mclk_in = 1'b0;
      forever #50 mclk_in = ~mclk_in;
   end
   // ********************
   // Helpers
   // ********************
   task check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task finish_test;
      $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task rest;
      {watchdog_in, firmware_irq_in, debug_rx_in, debug_tx_in, timer_flags_in, usb_hi_in, usb_lo_in,
       clock_ctl_in, mac_in, dma_in, can_in, motor_in, adc_done_in, uart_in, i2c_in, ssp_in,
       low_voltage_in, calendar_in, wake_in, usb_resume_in, prefetch_branch_cache_in, force_in, fast_en_in,
       fast_chan_in} <= '0;
      chan_en_in  <= '1;
      prim_map_in <= IDENT;
      sec_map_in  <= IDENT;
   endtask
   task step;
      @(posedge mclk_in);
   endtask
   // Waits past the fixed two-edge latency, then samples at the falling edge where all is settled
   task settle;
      repeat (3) @(posedge mclk_in);
      @(negedge mclk_in);
   endtask
   // Drives one bit of the source that feeds slot s
   task src(input int s, input logic v);
      case (s)
         0: watchdog_in <= v;
         1: firmware_irq_in <= v;
         2: debug_rx_in <= v;
         3: debug_tx_in <= v;
         4, 5, 6, 7: timer_flags_in[5*(s-4)+2] <= v;
         8: usb_hi_in <= v;
         9: usb_lo_in <= v;
         10: clock_ctl_in[7] <= v;
         11: mac_in[0] <= v;
         12: dma_in[7] <= v;
         13: can_in[3] <= v;
         14: motor_in[7] <= v;
         15: adc_done_in <= v;
         16, 17, 18: uart_in[5*(s-16)+4] <= v;
         19, 20: i2c_in[3*(s-19)+1] <= v;
         21, 22: ssp_in[8*(s-21)+7] <= v;
         23: low_voltage_in <= v;
         24: calendar_in[2] <= v;
         25: wake_in[31] <= v;
         26, 27, 28, 29: wake_in[8*(s-26)+3] <= v;
         30: usb_resume_in <= v;
         default: prefetch_branch_cache_in[3] <= v;
      endcase
   endtask
   task expect_win(input logic vr, input int ch, input int sr);
      check(vector_request_out, vr);
      check(active_chan_out, ch);
      check(active_source_out, sr);
      check(vector_addr_out, vr ? VEC_BASE + VEC_STRIDE * ch : VEC_IDLE);
   endtask
   // ********************
   // Scenarios
   // ********************
   task t_slots;
      for (int s = 0; s < NCH; s++) begin
         step();
         src(s, 1'b1);
         if (s >= SRC_WAKE_GRP && s < SRC_USB_RES) begin
            chan_en_in <= ~(32'h1 << SRC_WAKE_ALL);
         end
         settle();
         expect_win(1'b1, s, s);
         check(read_source, s);
         check(read_vector, VEC_BASE + VEC_STRIDE * s);
         step();
         src(s, 1'b0);
         chan_en_in <= '1;
         settle();
         check(vector_request_out, 1'b0);
      end
   endtask
   task t_prio;
      step();
      src(31, 1'b1);
      src(16, 1'b1);
      src(0, 1'b1);
      settle();
      expect_win(1'b1, 0, 0);
      step();
      src(0, 1'b0);
      src(15, 1'b1);
      prim_map_in <= {IDENT[63:4], 4'hf};
      sec_map_in  <= {IDENT[63:4], 4'hf};
      settle();
      expect_win(1'b1, 0, 15);
      step();
      src(15, 1'b0);
      settle();
      expect_win(1'b1, 16, 31);
      step();
      rest();
   endtask
   task t_force_enable;
      step();
      force_in <= 32'h8000_0000;
      settle();
      expect_win(1'b1, 31, 31);
      step();
      force_in <= '0;
      src(0, 1'b1);
      src(3, 1'b1);
      chan_en_in <= 32'hffff_fffe;
      settle();
      expect_win(1'b1, 3, 3);
      step();
      chan_en_in <= 32'hffff_fff6;
      settle();
      expect_win(1'b0, 0, 0);
      step();
      src(0, 1'b0);
      src(3, 1'b0);
      chan_en_in <= '1;
      force_in   <= 32'h0000_0001;
      settle();
      expect_win(1'b1, 0, 0);
      step();
      chan_en_in <= '0;
      settle();
      expect_win(1'b0, 0, 0);
      check(fast_request_out, 1'b0);
      step();
      rest();
   endtask
   // Mid-run reset with a source held: outputs clear, then the level is served again
   task t_reset;
      step();
      src(SRC_WATCHDOG, 1'b1);
      settle();
      expect_win(1'b1, 0, 0);
      step();
      rst_in <= 1'b1;
      settle();
      expect_win(1'b0, 0, 0);
      check(fast_request_out, 1'b0);
      step();
      rst_in <= 1'b0;
      settle();
      expect_win(1'b1, 0, 0);
      step();
      rest();
   endtask
   task t_fast;
      step();
      fast_en_in   <= 1'b1;
      fast_chan_in <= 5'h05;
      src(5, 1'b1);
      settle();
      check(fast_request_out, 1'b1);
      check(in_fast, 1'b1);
      expect_win(1'b0, 0, 0);
      step();
      src(31, 1'b1);
      settle();
      check(fast_request_out, 1'b1);
      expect_win(1'b1, 31, 31);
      step();
      rest();
   endtask
   initial begin
      fail_count = 0;
      samples_checked = 0;
      rst_in = 1'b1;
      rest();
      repeat (12) @(posedge mclk_in);
      rst_in <= 1'b0;
      t_slots();
      t_prio();
      t_force_enable();
      t_fast();
      t_reset();
      finish_test();
   end
   // Hang guard: a bounded count of edges, then the closing report
   initial begin
      repeat (20000) @(posedge mclk_in);
      fail_count++;
      finish_test();
   end
endmodule
